/* File: dv/testbench.sv */
// self-checking bench for wiper_host
// assumes the device model and checker files are compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clk = 0, arst_n = 0, ce = 1, cmd_valid = 0, cmd_up = 0, cmd_hv = 0, cmd_alt = 0, pwr = 1;
	logic [5:0] cmd_steps = 6'h00, e;
	wire cmd_ready, sel_low, sel_overdrive, dir, busy;
	wire [5:0] wiper, pos;
	int fails = 0, checks_done = 0;
	always #5 clk = ~clk;
	wiper_host wiper_host_inst(.clk(clk), .arst_n(arst_n), .ce(ce), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_up(cmd_up), .cmd_hv(cmd_hv), .cmd_alt(cmd_alt), .cmd_steps(cmd_steps), .dev_reloaded(pwr),
		.sel_low(sel_low), .sel_overdrive(sel_overdrive), .dir(dir), .wiper(wiper), .busy(busy));
	wiper_dev_model wiper_dev_model_inst(.sel_low(sel_low), .sel_overdrive(sel_overdrive), .dir(dir),
		.power_ok(pwr), .pos(pos));
	// one command, then wait for the host to go idle
	task automatic cmd(input logic u, h, a, input logic [5:0] n);
		@(negedge clk);
		{cmd_valid, cmd_up, cmd_hv, cmd_alt, cmd_steps} = {1'b1, u, h, a, n};
		@(negedge clk);
		cmd_valid = 0;
		repeat (12) @(negedge clk);
		checks_done++;
		if ({sel_low, sel_overdrive, cmd_ready} !== {~h, h, 1'b0}) begin
			fails++;
			$display("unexpected at %0t: select 0x%h want 0x%h", $time, {sel_low, sel_overdrive, cmd_ready}, {~h, h, 1'b0});
		end
		for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(negedge clk);
	endtask
	// shadow and device must agree with the expected code
	task automatic check(input logic [5:0] x);
		checks_done++;
		if (wiper !== x || pos !== x || busy !== 1'b0 || cmd_ready !== 1'b1) begin
			fails++;
			$display("unexpected at %0t: 0x%h 0x%h want 0x%h", $time, wiper, pos, x);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic t_modes; // all eight command forms, three steps each
		e = 6'h1F;
		for (int k = 0; k < 8; k++) begin
			cmd(k[0], k[1], k[2], 6'h03);
			e = k[0] ? e + 6'h03 : e - 6'h03;
			check(e);
		end
		$display("modes done");
	endtask
	task automatic t_ends; // saturation at both ends
		cmd(0, 0, 0, 6'h3F);
		check(6'h00);
		cmd(1, 0, 1, 6'h3F);
		check(6'h3F);
		cmd(1, 1, 0, 6'h02);
		check(6'h3F);
		$display("ends done");
	endtask
	task automatic t_reload; // supply dip reloads mid-scale
		@(negedge clk);
		pwr = 0;
		repeat (4) @(negedge clk);
		pwr = 1;
		repeat (4) @(negedge clk);
		check(6'h1F);
		$display("reload done");
	endtask
	task automatic t_power_on; // shadow and device both start at mid-scale
		repeat (4) @(negedge clk);
		check(6'h1F);
		$display("power-on done");
	endtask
	task automatic t_freeze; // clock enable low mid-command holds select, dir, busy and wiper, no step lost
		logic [9:0] snap;
		fork
			cmd(1, 0, 0, 6'h02);
			begin
				repeat (30) @(negedge clk);
				ce = 0;
				snap = {sel_low, sel_overdrive, dir, busy, wiper};
				repeat (19) @(negedge clk);
				checks_done++;
				if ({sel_low, sel_overdrive, dir, busy, wiper} !== snap) begin
					fails++;
					$display("unexpected at %0t: 0x%h want 0x%h", $time, {sel_low, sel_overdrive, dir, busy, wiper}, snap);
				end
				ce = 1;
			end
		join
		check(6'h21);
		$display("freeze done");
	endtask
	initial begin
		repeat (3) @(negedge clk);
		arst_n = 1;
		t_power_on();
		t_modes();
		t_ends();
		t_reload();
		t_freeze();
		end_sim();
	end
	initial begin
		#200000;
		fails++;
		end_sim();
	end
endmodule // testbench
`default_nettype wire

/* File: dv/wiper_dev_model.sv */
// behavioural up/down wiper device
// assumes decoded select pins from the host
`timescale 1ns/100ps
`default_nettype none
module wiper_dev_model (
	input wire logic       sel_low,       // select low
	input wire logic       sel_overdrive, // select overdrive
	input wire logic       dir,           // step pin
	input wire logic       power_ok,      // supply in range
	output var logic [5:0] pos            // wiper, no readback pin
);
	logic dir_q; // delayed copy, host may move dir on the select edge
	wire  sel = sel_low | sel_overdrive;
	initial pos = 6'h1F;
	always @(posedge power_ok) pos = 6'h1F;
	always @(dir) dir_q <= #1 dir;
	logic up;
	// mode latched on leaving idle
	always @(posedge sel) up = dir_q;
	always @(posedge dir) if (sel) begin
		if (up && pos != 6'h3F) pos = pos + 6'h01;
		else if (!up && pos != 6'h00) pos = pos - 6'h01;
	end
endmodule // wiper_dev_model
`default_nettype wire

/* File: dv/wiper_host_monitor.sv */
// pin checker for the wiper host controller
// assumes it is bound to wiper_host
`timescale 1ns/100ps
`default_nettype none
module wiper_host_monitor (
	input wire logic       clk,           // clock
	input wire logic       arst_n,        // reset, active low
	input wire logic       sel_low,       // select low
	input wire logic       sel_overdrive, // select overdrive
	input wire logic       dir,           // step pin
	input wire logic [5:0] wiper,         // tracked position
	input wire logic       busy           // command active
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// one select level at a time, never both
	chk_sel_exclusive: assert property (!(sel_low && sel_overdrive)) else $error("both selects");
	chk_no_wrap: assert property ((sel_low || sel_overdrive) && $changed(wiper) |->
		($past(wiper) != 6'h3F || wiper != 6'h00) && ($past(wiper) != 6'h00 || wiper != 6'h3F)) else $error("wrap");
	chk_step_cause: assert property ($changed(wiper) && $past(sel_low || sel_overdrive) |-> $rose(dir)) else $error("step");
	chk_idle_dir: assert property (!busy |-> !dir) else $error("dir idle");
	chk_sel_in_busy: assert property (sel_low || sel_overdrive |-> busy) else $error("sel idle");
	chk_sel_setup: assert property ($rose(sel_low || sel_overdrive) |-> $past(busy, 2)) else $error("setup");
	chk_end_release: assert property ($fell(sel_low || sel_overdrive) |-> ##[1:12] !busy) else $error("end");
	chk_dir_settled: assert property ($fell(sel_low || sel_overdrive) |-> $stable(dir)) else $error("end dir");
	chk_dir_hold: assert property ($rose(sel_low || sel_overdrive) |-> $stable(dir)) else $error("dir at select");
	chk_step_tracked: assert property ($rose(dir) && (sel_low || sel_overdrive) |->
		$changed(wiper) || wiper == 6'h3F || wiper == 6'h00) else $error("untracked step");
endmodule // wiper_host_monitor
bind wiper_host wiper_host_monitor wiper_host_monitor_inst(.clk(clk), .arst_n(arst_n), .sel_low(sel_low),
	.sel_overdrive(sel_overdrive), .dir(dir), .wiper(wiper), .busy(busy));
`default_nettype wire

/* File: rtl/wiper_host.v */
// wiper_host.v: host that drives an up/down wiper device through its select and direction pins
// assumes the device decodes select into select-low and select-overdrive, and updates on direction rising edges
//
// How it works
// - eight commands; select low for normal, overdrive level for high-voltage.
// - host holds select idle high before and between commands.
// - direction high at select fall gives increment; each rise steps up.
// - direction low at select fall gives decrement; each rise steps down.
// - compatibility increment ends direction low, then select returns idle.
// - plain decrement ends direction low, then select returns idle.
// - compatibility decrement of one or more steps ends direction high while select returns idle.
// - select returns idle two phases after the final step, at the end of the END phase.
// - a new command may start one phase after select is idle again, once busy drops.
// - overdrive commands pick direction the same way, each rise steps once.
`timescale 1ns/100ps
`default_nettype none
`include "wiper_host_map.vh"

module wiper_host (
	input  wire       clk,            // 100 MHz clock
	input  wire       arst_n,         // async reset, active low
	input  wire       ce,             // clock enable, freezes all state but the reset synchroniser when low
	input  wire       cmd_valid,      // command request
	output wire       cmd_ready,      // host idle, command accepted
	input  wire       cmd_up,         // 1 increment, 0 decrement
	input  wire       cmd_hv,         // use overdrive-level select
	input  wire       cmd_alt,        // compatibility / variant-2 ending
	input  wire [5:0] cmd_steps,      // number of steps, 0 allowed
	input  wire       dev_reloaded,   // device power-up or brown-out seen (async)
	output reg        sel_low,        // select at low level
	output reg        sel_overdrive,  // select at overdrive_level
	output reg        dir,            // direction/step pin
	output reg  [5:0] wiper,          // tracked wiper position
	output reg        busy            // command in progress
);

	localparam [5:0] S_IDLE  = 6'b00_0001;
	localparam [5:0] S_SETUP = 6'b00_0010;
	localparam [5:0] S_LOW   = 6'b00_0100;
	localparam [5:0] S_HIGH  = 6'b00_1000;
	localparam [5:0] S_END   = 6'b01_0000;
	localparam [5:0] S_REL   = 6'b10_0000;

	reg  [1:0]                 rst_sync;     // reset release stages
	wire                       rst_n;        // synchronised reset, active low
	reg  [1:0]                 reload_sync;  // reload pin stages
	reg                        reload_seen;  // second stage, one cycle late
	wire                       reload_edge;  // rising edge of the reload pin
	reg                        reload_pend;  // reload seen mid-command, waiting for idle
	reg  [5:0]                 state;        // one-hot sequencer state
	reg  [5:0]                 next_state;   // state after this cycle
	reg  [`PHASE_CNT_BITS-1:0] tmr;          // phase timer, counts down to zero
	wire                       phase_done;   // current phase has run out
	wire                       accept;       // command taken this cycle
	reg  [5:0]                 left;         // steps still to issue
	reg                        up;           // latched direction
	reg                        hv;           // latched select level
	reg                        end_dir;      // direction level before select returns

	// saturating step of the shadow position
	function [5:0] step_wiper;
		input [5:0] w;
		input       inc;
		begin
			if (inc)
				step_wiper = (w == `WIPER_TOP) ? w : w + 6'h01;
			else
				step_wiper = (w == `WIPER_BOTTOM) ? w : w - 6'h01;
		end
	endfunction

	// reset release through two flops
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end

	// ready only when idle and out of reset, so a request made during reset is not taken
	assign rst_n       = rst_sync[1];
	assign cmd_ready   = (state == S_IDLE) && rst_n;
	assign accept      = cmd_valid && cmd_ready && ce;
	assign phase_done  = (tmr == {`PHASE_CNT_BITS{1'b0}});
	assign reload_edge = reload_sync[1] && !reload_seen;

	// reload pin synchroniser; edge detect reads only the second stage
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reload_sync <= 2'b00;
			reload_seen <= 1'b0;
		end else if (ce) begin
			reload_sync <= {reload_sync[0], dev_reloaded};
			reload_seen <= reload_sync[1];
		end
	end

	// reload seen mid-command waits for idle; steps issued after the dip
	// cannot be known, so the shadow is a best guess until the next command
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reload_pend <= 1'b0;
		end else if (ce) begin
			if (reload_edge && (state != S_IDLE))
				reload_pend <= 1'b1;
			else if (state == S_IDLE)
				reload_pend <= 1'b0;
		end
	end

	// next state; every active phase runs until the timer reaches zero
	always @* begin
		next_state = state;
		case (state)
		S_IDLE:
			if (accept)
				next_state = S_SETUP;
		S_SETUP:
			if (phase_done)
				next_state = S_HIGH;
		S_HIGH:
			if (phase_done)
				next_state = (left == 6'h00) ? S_END : S_LOW;
		S_LOW:
			if (phase_done)
				next_state = S_HIGH;
		S_END:
			if (phase_done)
				next_state = S_REL;
		S_REL:
			if (phase_done)
				next_state = S_IDLE;
		default:
			next_state = S_IDLE;
		endcase
	end

	// state register; ce low holds the sequencer mid-phase
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			state <= S_IDLE;
		else if (ce)
			state <= next_state;
	end

	// phase timer: reloaded on each move to an active state, so a phase lasts PHASE_CYC + 1 cycles
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tmr <= {`PHASE_CNT_BITS{1'b0}};
		end else if (ce) begin
			if ((next_state != state) && (next_state != S_IDLE))
				tmr <= `PHASE_CYC;
			else if (!phase_done)
				tmr <= tmr - {{(`PHASE_CNT_BITS-1){1'b0}}, 1'b1};
		end
	end

	// pin and shadow updates; pins move at phase ends and dir also on accept, so every level is held a full phase while busy
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sel_low       <= 1'b0;
			sel_overdrive <= 1'b0;
			dir           <= 1'b0;
			wiper         <= `WIPER_DEFAULT;
			busy          <= 1'b0;
			left          <= 6'h00;
			up            <= 1'b0;
			hv            <= 1'b0;
			end_dir       <= 1'b0;
		end else if (ce) begin
			case (state)
			S_IDLE: begin
				// device reloaded behind our back: resync shadow, only between commands
				if (reload_edge || reload_pend)
					wiper <= `WIPER_DEFAULT;
				if (accept) begin
					up      <= cmd_up;
					hv      <= cmd_hv;
					left    <= cmd_steps;
					// ending level: low for plain/compat inc and plain dec, high for compat dec
					end_dir <= cmd_alt ? ~cmd_up : 1'b0;
					dir     <= cmd_up;
					busy    <= 1'b1;
				end
			end
			S_SETUP:
				if (phase_done) begin
					// leave idle; direction settled a phase ago and held through this edge
					sel_low       <= ~hv;
					sel_overdrive <= hv;
				end
			S_HIGH:
				if (phase_done) begin
					// dir may only fall here: raising it with select active would be a step
					if (left == 6'h00)
						dir <= dir & end_dir;
					else
						dir <= 1'b0;
				end
			S_LOW:
				if (phase_done) begin
					dir   <= 1'b1;
					wiper <= step_wiper(wiper, up);
					left  <= left - 6'h01;
				end
			S_END:
				if (phase_done) begin
					// back to idle promptly so no stray edge steps the wiper
					sel_low       <= 1'b0;
					sel_overdrive <= 1'b0;
				end
			S_REL:
				if (phase_done) begin
					dir  <= 1'b0;
					busy <= 1'b0;
				end
			default: begin
				sel_low       <= 1'b0;
				sel_overdrive <= 1'b0;
				dir           <= 1'b0;
				busy          <= 1'b0;
			end
			endcase
		end
	end

endmodule // wiper_host

`default_nettype wire

/* File: rtl/wiper_host_map.vh */
// wiper_host_map.vh: constants for the up/down wiper host controller
// assumes a 100 MHz clock; included by bare name
`ifndef WIPER_HOST_MAP_VH
`define WIPER_HOST_MAP_VH

`define CLK_PERIOD_NS      10
`define WIPER_BITS         6
`define WIPER_TOP          6'h3F
`define WIPER_BOTTOM       6'h00
`define WIPER_DEFAULT      6'h1F
`define PHASE_NS           100
`define PHASE_CYC          4'hA  // PHASE_NS over CLK_PERIOD_NS, rounded up; sized to the phase timer
`define PHASE_CNT_BITS     4
`define END_NORMAL_INC     2'h0
`define END_COMPAT_INC     2'h1
`define END_COMPAT_DEC     2'h2

`endif
